// ==== verilog/rwm_params.svh ====
// offsets, field positions and reset values of the rx word map block
// assumes a 32-bit apb register bus, one aligned word per register
`ifndef RWM_PARAMS_SVH
`define RWM_PARAMS_SVH

// ==========================================================
// register byte offsets
`define RWM_OFS_CTRL 12'h000
`define RWM_OFS_IRQ_STAT 12'h004
`define RWM_OFS_IRQ_MASK 12'h008
`define RWM_OFS_LAST_WORD 12'h00C

// ==========================================================
// control register fields
`define RWM_CTRL_PIPE 0
`define RWM_CTRL_RX_DIV2 1
`define RWM_CTRL_RX_MODE_LO 2
`define RWM_CTRL_RX_MODE_HI 3
`define RWM_CTRL_TX_PER_CH 4
`define RWM_CTRL_TX_CORE 5
`define RWM_CTRL_RX_CORE 6
`define RWM_CTRL_W 7
`define RWM_CTRL_RST 7'h00

// ==========================================================
// interrupt status / mask fields
`define RWM_IRQ_DISPERR 0
`define RWM_IRQ_RM_DEL 1
`define RWM_IRQ_RM_INS 2
`define RWM_IRQ_SYNC_LOST 3
`define RWM_IRQ_W 4
`define RWM_IRQ_RST 4'h0

// ==========================================================
// output word layout, per 16-bit half
`define RWM_HALF_W 16
`define RWM_BIT_SYNC 10
`define RWM_BIT_DISPERR 11
`define RWM_BIT_PATDET 12
`define RWM_BIT_RM_DEL 13
`define RWM_BIT_RM_INS 14
`define RWM_BIT_RUNDISP 15

`endif

// ==== verilog/rwm_pkg.sv ====
// types shared by the rx word map block
// assumes rwm_params.svh for the numeric layout
package rwm_pkg;

	// ==========================================================
	// one received symbol with its status flags
	typedef struct packed {
		logic [9:0] data;
		logic sync;
		logic disperr;
		logic patdet;
		logic rm_del;
		logic rm_ins;
		logic [1:0] pipe_st;
		logic rundisp;
	} rwm_sym_t;

	// ==========================================================
	// symbol pair from the pcs, first symbol in lo
	typedef struct packed {
		logic valid;
		rwm_sym_t hi;
		rwm_sym_t lo;
	} rwm_pair_t;

	// ==========================================================
	// receiver core clock source
	typedef enum logic [1:0] {
		RWM_RX_SHARED_TX0,
		RWM_RX_PER_TX,
		RWM_RX_PER_RX,
		RWM_RX_RSVD
	} rwm_rx_mode_t;

endpackage : rwm_pkg

// ==== verilog/rwm_top.sv ====
// rx word map, rx divide-by-two and core clock selection with apb registers
// assumes symbol pairs arrive on pclk; clock pins are asynchronous levels
`timescale 1ns/1ps
`include "rwm_params.svh"

// Functional notes
// - symbols on bits 9:0 and 25:16
// - sync status on bits 10 and 26
// - disparity error on bits 11 and 27
// - pattern detect on bits 12 and 28
// - rate-match delete on 13, 29 outside pipe
// - rate-match insert on 14, 30 outside pipe
// - running disparity on bits 15 and 31
// - pipe mode puts pipe status there
// - receiver offers local divide-by-two
// - divide option on receive path only
// - user tx core clock overrides tx clkout
// - user rx core clock overrides rx clkout
// - shared tx: channel 0 clkout writes all
// - per-channel tx: own clkout writes fifo
// - shared rx: channel 0 tx clkout reads
// - per-channel tx clock reads rx fifo
// - per-channel rx clkout reads rx fifo
module rwm_top #(
	parameter int NCH = 4
) (
	input wire logic pclk, // bus and block clock
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire rwm_pkg::rwm_pair_t rx_pair, // symbol pair from pcs
	output logic [31:0] rx_word, // packed fabric word
	output logic rx_word_valid, // one-cycle pulse per word
	input wire logic [NCH-1:0] tx_clkout, // channel tx output clocks
	input wire logic [NCH-1:0] rx_clkout, // channel rx output clocks
	input wire logic [NCH-1:0] tx_coreclk, // user tx core clocks
	input wire logic [NCH-1:0] rx_coreclk, // user rx core clocks
	output logic [NCH-1:0] txfifo_wclk, // selected tx fifo write clock
	output logic [NCH-1:0] rxfifo_rclk, // selected rx fifo read clock
	output logic irq // level interrupt
);

	// refuse channel counts the select logic cannot serve
	if (NCH < 1 || NCH > 32) begin : g_bad_nch
		$error("rwm_top: NCH must be 1 to 32");
	end

	// ==========================================================
	// apb decode
	logic [`RWM_CTRL_W-1:0] ctrl_q;
	logic [`RWM_IRQ_W-1:0] stat_q;
	logic [`RWM_IRQ_W-1:0] stat_d;
	logic [`RWM_IRQ_W-1:0] mask_q;
	logic [31:0] last_q;

	wire logic acc = psel && penable && ce;
	wire logic hit_ctrl = (paddr == `RWM_OFS_CTRL);
	wire logic hit_stat = (paddr == `RWM_OFS_IRQ_STAT);
	wire logic hit_mask = (paddr == `RWM_OFS_IRQ_MASK);
	wire logic hit_last = (paddr == `RWM_OFS_LAST_WORD);
	wire logic hit_any = hit_ctrl || hit_stat || hit_mask || hit_last;
	wire logic wr_ctrl = acc && pwrite && hit_ctrl;
	wire logic wr_stat = acc && pwrite && hit_stat;
	wire logic wr_mask = acc && pwrite && hit_mask;

	// bus stalls with the block so no write lands while frozen
	assign pready = ce;
	assign pslverr = psel && penable && !hit_any;

	wire logic [31:0] rd_mux = hit_ctrl ? {{(32-`RWM_CTRL_W){1'b0}}, ctrl_q} :
		hit_stat ? {{(32-`RWM_IRQ_W){1'b0}}, stat_q} :
		hit_mask ? {{(32-`RWM_IRQ_W){1'b0}}, mask_q} :
		hit_last ? last_q : 32'h0000_0000;
	assign prdata = (psel && penable && !pwrite) ? rd_mux : 32'h0000_0000;

	// ==========================================================
	// control fields
	wire logic pipe_mode = ctrl_q[`RWM_CTRL_PIPE];
	wire logic rx_div2 = ctrl_q[`RWM_CTRL_RX_DIV2];
	wire rwm_pkg::rwm_rx_mode_t rx_mode =
		rwm_pkg::rwm_rx_mode_t'(ctrl_q[`RWM_CTRL_RX_MODE_HI:`RWM_CTRL_RX_MODE_LO]);
	wire logic tx_per_ch = ctrl_q[`RWM_CTRL_TX_PER_CH];
	wire logic tx_core_en = ctrl_q[`RWM_CTRL_TX_CORE];
	wire logic rx_core_en = ctrl_q[`RWM_CTRL_RX_CORE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `RWM_CTRL_RST;
			mask_q <= `RWM_IRQ_RST;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata[`RWM_CTRL_W-1:0];
			end
			if (wr_mask) begin
				mask_q <= pwdata[`RWM_IRQ_W-1:0];
			end
		end
	end

	// ==========================================================
	// symbol packing
	function automatic logic [`RWM_HALF_W-1:0] map_sym(input rwm_pkg::rwm_sym_t s, input logic pipe);
		logic [`RWM_HALF_W-1:0] h;
		h = '0;
		h[9:0] = s.data;
		h[`RWM_BIT_SYNC] = s.sync;
		h[`RWM_BIT_DISPERR] = s.disperr;
		h[`RWM_BIT_PATDET] = s.patdet;
		if (pipe) begin
			h[`RWM_BIT_RM_INS:`RWM_BIT_RM_DEL] = s.pipe_st;
		end else begin
			h[`RWM_BIT_RM_DEL] = s.rm_del;
			h[`RWM_BIT_RM_INS] = s.rm_ins;
		end
		h[`RWM_BIT_RUNDISP] = s.rundisp;
		return h;
	endfunction : map_sym

	wire logic [31:0] word_d = {map_sym(rx_pair.hi, pipe_mode), map_sym(rx_pair.lo, pipe_mode)};

	// ==========================================================
	// receive divide-by-two
	logic phase_q;
	wire logic take = rx_pair.valid && (!rx_div2 || !phase_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 1'b0;
			rx_word <= 32'h0000_0000;
			rx_word_valid <= 1'b0;
			last_q <= 32'h0000_0000;
		end else if (ce) begin
			rx_word_valid <= take;
			if (rx_pair.valid) begin
				phase_q <= rx_div2 ? !phase_q : 1'b0;
			end
			if (take) begin
				rx_word <= word_d;
				last_q <= word_d;
			end
		end
	end

	// ==========================================================
	// interrupt events
	logic sync_prev_q;
	wire logic ev_disperr = take && (rx_pair.lo.disperr || rx_pair.hi.disperr);
	wire logic ev_rm_del = take && !pipe_mode && (rx_pair.lo.rm_del || rx_pair.hi.rm_del);
	wire logic ev_rm_ins = take && !pipe_mode && (rx_pair.lo.rm_ins || rx_pair.hi.rm_ins);
	wire logic ev_sync_lost = take && sync_prev_q && !(rx_pair.lo.sync && rx_pair.hi.sync);
	wire logic [`RWM_IRQ_W-1:0] ev = {ev_sync_lost, ev_rm_ins, ev_rm_del, ev_disperr};
	wire logic [`RWM_IRQ_W-1:0] clr = wr_stat ? pwdata[`RWM_IRQ_W-1:0] : '0;

	// a new event beats a write-one-to-clear in the same cycle
	assign stat_d = (stat_q & ~clr) | ev;
	assign irq = |(stat_q & mask_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= `RWM_IRQ_RST;
			sync_prev_q <= 1'b0;
		end else if (ce) begin
			stat_q <= stat_d;
			if (take) begin
				sync_prev_q <= rx_pair.lo.sync && rx_pair.hi.sync;
			end
		end
	end

	// ==========================================================
	// core clock selection per channel
	// clock pins are seen as sampled levels, so edges faster than pclk/2 alias
	logic [NCH-1:0] txo_m_q, txo_s_q, rxo_m_q, rxo_s_q;
	logic [NCH-1:0] txc_m_q, txc_s_q, rxc_m_q, rxc_s_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txo_m_q <= '0;
			txo_s_q <= '0;
			rxo_m_q <= '0;
			rxo_s_q <= '0;
			txc_m_q <= '0;
			txc_s_q <= '0;
			rxc_m_q <= '0;
			rxc_s_q <= '0;
		end else if (ce) begin
			txo_m_q <= tx_clkout;
			txo_s_q <= txo_m_q;
			rxo_m_q <= rx_clkout;
			rxo_s_q <= rxo_m_q;
			txc_m_q <= tx_coreclk;
			txc_s_q <= txc_m_q;
			rxc_m_q <= rx_coreclk;
			rxc_s_q <= rxc_m_q;
		end
	end

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic tx_sel;
		logic rx_sel;
		logic twc_q;
		logic rrc_q;

		wire logic tx_loop = tx_per_ch ? txo_s_q[i] : txo_s_q[0];
		wire logic rx_loop = (rx_mode == rwm_pkg::RWM_RX_SHARED_TX0) ? txo_s_q[0] :
			(rx_mode == rwm_pkg::RWM_RX_PER_TX) ? txo_s_q[i] : rxo_s_q[i];

		assign tx_sel = tx_core_en ? txc_s_q[i] : tx_loop;
		assign rx_sel = rx_core_en ? rxc_s_q[i] : rx_loop;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				twc_q <= 1'b0;
				rrc_q <= 1'b0;
			end else if (ce) begin
				twc_q <= tx_sel;
				rrc_q <= rx_sel;
			end
		end

		assign txfifo_wclk[i] = twc_q;
		assign rxfifo_rclk[i] = rrc_q;
	end

endmodule : rwm_top

// ==== tb/rwm_props.sv ====
// port checker for rwm_top, bound onto it
// assumes one pclk domain and presetn reset
`timescale 1ns/1ps
module rwm_props (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic ce, // clock enable
	input wire logic pready, // apb ready
	input wire rwm_pkg::rwm_pair_t rx_pair, // pcs pair
	input wire logic [31:0] rx_word, // packed word
	input wire logic rx_word_valid // word pulse
);
	// ========
	// word map and apb ready properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ce gate: a frozen pulse is not a fresh word
	sequence took;
		$past(ce) && rx_word_valid;
	endsequence
	lo_data_a: assert property (took |-> rx_word[9:0] == $past(rx_pair.lo.data)) else $error("lo data");
	hi_data_a: assert property (took |-> rx_word[25:16] == $past(rx_pair.hi.data)) else $error("hi data");
	sync_bits_a: assert property (took |-> {rx_word[26], rx_word[10]} == $past({rx_pair.hi.sync, rx_pair.lo.sync}))
		else $error("sync");
	disp_err_a: assert property (took |-> rx_word[27] == $past(rx_pair.hi.disperr) && rx_word[11] == $past(rx_pair.lo.disperr))
		else $error("disperr");
	pat_det_a: assert property (took |-> rx_word[28] == $past(rx_pair.hi.patdet) && rx_word[12] == $past(rx_pair.lo.patdet))
		else $error("patdet");
	run_disp_a: assert property (took |-> rx_word[31] == $past(rx_pair.hi.rundisp) && rx_word[15] == $past(rx_pair.lo.rundisp))
		else $error("rundisp");
	idle_word_a: assert property (ce && !rx_pair.valid |=> !rx_word_valid) else $error("stray word");
	ready_ce_a: assert property (pready == ce) else $error("pready");
endmodule : rwm_props
bind rwm_top rwm_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .pready(pready), .rx_pair(rx_pair),
	.rx_word(rx_word), .rx_word_valid(rx_word_valid));

// ==== tb/rwm_fab.sv ====
// fabric-side user logic: supplies the user core clocks
// assumes pattern levels come from the bench
`timescale 1ns/1ps
module rwm_fab (
	input wire logic pclk, // clock
	input wire logic [3:0] tx_pat, // wanted tx core level
	input wire logic [3:0] rx_pat, // wanted rx core level
	output logic [3:0] tx_coreclk, // user tx core clocks
	output logic [3:0] rx_coreclk // user rx core clocks
);
	// ========
	// user clock supply
	always_ff @(posedge pclk) begin
		tx_coreclk <= tx_pat;
		rx_coreclk <= rx_pat;
	end
endmodule : rwm_fab

// ==== tb/rwm_top_tb.sv ====
// bench for rwm_top: apb, word map, div2, clock select
// assumes rwm_fab drives the user core clocks
`timescale 1ns/1ps
`include "rwm_params.svh"
module rwm_top_tb;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, q, prdata, rx_word;
	logic pready, pslverr, rx_word_valid, irq;
	logic [3:0] tx_clkout = '0, rx_clkout = '0, tx_pat = '0, rx_pat = '0;
	logic [3:0] tx_coreclk, rx_coreclk, txfifo_wclk, rxfifo_rclk;
	rwm_pkg::rwm_pair_t rx_pair = '0;
	rwm_pkg::rwm_sym_t pat [4] = '{18'h3FFFF, 18'h15555, 18'h2AAAA, 18'h00000};
	int miscompares = 0, n_checks = 0, k;
	always #5 pclk = ~pclk;
	rwm_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_pair(rx_pair), .rx_word(rx_word), .rx_word_valid(rx_word_valid), .tx_clkout(tx_clkout),
		.rx_clkout(rx_clkout), .tx_coreclk(tx_coreclk), .rx_coreclk(rx_coreclk),
		.txfifo_wclk(txfifo_wclk), .rxfifo_rclk(rxfifo_rclk), .irq(irq));
	rwm_fab fab (.pclk(pclk), .tx_pat(tx_pat), .rx_pat(rx_pat), .tx_coreclk(tx_coreclk), .rx_coreclk(rx_coreclk));
	// ========
	// tasks
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, x, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// let the edge's register updates settle before callers look
		#1;
		if (n >= 50) begin
			miscompares++;
			wrap_up();
		end
	endtask : apb
	task automatic send(input rwm_pkg::rwm_sym_t lo, input rwm_pkg::rwm_sym_t hi);
		@(posedge pclk);
		rx_pair <= '{1'b1, hi, lo};
		@(posedge pclk);
		rx_pair.valid <= 1'b0;
		#1;
	endtask : send
	function automatic logic [15:0] half(input rwm_pkg::rwm_sym_t s, input logic p);
		return {s.rundisp, p ? s.pipe_st : {s.rm_ins, s.rm_del}, s.patdet, s.disperr, s.sync, s.data};
	endfunction : half
	// core clocks get the inverse pattern so an override is visible
	task automatic ck(input logic [6:0] c, input logic [3:0] t, input logic [3:0] r, input logic [7:0] x);
		apb(1'b1, `RWM_OFS_CTRL, {25'h0, c});
		tx_clkout <= t;
		rx_clkout <= r;
		tx_pat <= ~t;
		rx_pat <= ~r;
		repeat (6) @(posedge pclk);
		#1;
		chk("clk", {24'h0, x}, {24'h0, txfifo_wclk, rxfifo_rclk});
	endtask : ck
	// ========
	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `RWM_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0, q);
		apb(1'b0, 12'h010, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		for (k = 0; k < 4; k++) begin
			send(pat[k], ~pat[k]);
			chk("word", {half(~pat[k], 1'b0), half(pat[k], 1'b0)}, rx_word);
		end
		apb(1'b1, `RWM_OFS_CTRL, 32'h1);
		send(pat[1], pat[2]);
		chk("pipe", {half(pat[2], 1'b1), half(pat[1], 1'b1)}, rx_word);
		apb(1'b0, `RWM_OFS_LAST_WORD, 32'h0);
		chk("last", {half(pat[2], 1'b1), half(pat[1], 1'b1)}, q);
		apb(1'b1, `RWM_OFS_IRQ_MASK, 32'h1);
		apb(1'b1, `RWM_OFS_IRQ_STAT, 32'hF);
		chk("irq", 32'h0, {31'h0, irq});
		send(pat[0], pat[3]);
		@(posedge pclk);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, `RWM_OFS_IRQ_MASK, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b1, `RWM_OFS_CTRL, 32'h2);
		k = 0;
		@(posedge pclk);
		rx_pair.valid <= 1'b1;
		repeat (4) begin
			@(posedge pclk);
			#1;
			k += rx_word_valid;
		end
		rx_pair.valid <= 1'b0;
		@(posedge pclk);
		#1;
		k += rx_word_valid;
		chk("div2", 32'h2, 32'(k));
		ck(7'h00, 4'h1, 4'h6, 8'hFF);
		ck(7'h14, 4'h5, 4'h6, 8'h55);
		ck(7'h18, 4'h5, 4'h6, 8'h56);
		ck(7'h78, 4'h5, 4'h6, 8'hA9);
		ck(7'h12, 4'h5, 4'h6, 8'h5F);
		wrap_up();
	end
endmodule : rwm_top_tb
